// File: sttap_engine.sv
`timescale 1ns/1ns
module sttap_engine
	import sttap_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [DATA_W-1:0] func_in,
	output sttap_tdo_t tdo,
	output logic [DATA_W-1:0] func_out,
	output logic bypass_active,
	output logic [STTAP_IR_W-1:0] active_instr,
	output logic [DATA_W-1:0] data_update,
	output sttap_state_t tap_state
);
	logic [1:0] tck_sync;
	logic [1:0] tms_sync;
	logic [1:0] tdi_sync;
	logic [DATA_W-1:0] fin_s1;
	logic [DATA_W-1:0] fin_s2;
	logic tck_prev;
	logic [STTAP_IR_W-1:0] ir_shift;
	logic bypass_reg;
	logic [DATA_W-1:0] dr_shift;
	logic [DATA_W-1:0] func_samp;
	sttap_state_t state;
	sttap_state_t next_state;

	// synchronisers: first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tck_sync <= 2'h0;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h0;
			fin_s1 <= '0;
			fin_s2 <= '0;
		end
		else
		begin
			tck_sync <= {tck_sync[0], tck};
			tms_sync <= {tms_sync[0], tms};
			tdi_sync <= {tdi_sync[0], tdi};
			fin_s1 <= func_in;
			fin_s2 <= fin_s1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			tck_prev <= 1'b0;
		else
			tck_prev <= tck_sync[1];
	end

	wire tck_rise = tck_sync[1] & ~tck_prev;
	wire tck_fall = ~tck_sync[1] & tck_prev;
	wire tms_s = tms_sync[1];
	wire tdi_s = tdi_sync[1];

	always_comb
	begin
		next_state = state;
		case (state)
			TLR: next_state = tms_s ? TLR : RTI;
			RTI: next_state = tms_s ? SEL_DR : RTI;
			SEL_DR: next_state = tms_s ? SEL_IR : CAP_DR;
			CAP_DR: next_state = tms_s ? EX1_DR : SH_DR;
			SH_DR: next_state = tms_s ? EX1_DR : SH_DR;
			EX1_DR: next_state = tms_s ? UPD_DR : PAU_DR;
			PAU_DR: next_state = tms_s ? EX2_DR : PAU_DR;
			EX2_DR: next_state = tms_s ? UPD_DR : SH_DR;
			UPD_DR: next_state = tms_s ? SEL_DR : RTI;
			SEL_IR: next_state = tms_s ? TLR : CAP_IR;
			CAP_IR: next_state = tms_s ? EX1_IR : SH_IR;
			SH_IR: next_state = tms_s ? EX1_IR : SH_IR;
			EX1_IR: next_state = tms_s ? UPD_IR : PAU_IR;
			PAU_IR: next_state = tms_s ? EX2_IR : PAU_IR;
			EX2_IR: next_state = tms_s ? UPD_IR : SH_IR;
			UPD_IR: next_state = tms_s ? SEL_DR : RTI;
			default: next_state = TLR;
		endcase
	end

	// controller advances on rising test clock edge with sampled mode select
	always_ff @(posedge clk)
	begin
		if (rst)
			state <= TLR;
		else if (tck_rise)
			state <= next_state;
	end

	assign tap_state = state;

	wire in_sh_ir = (state == SH_IR);
	wire in_sh_dr = (state == SH_DR);

	// instruction shift stage
	always_ff @(posedge clk)
	begin
		if (rst)
			ir_shift <= STTAP_IR_CAPTURE;
		else if (tck_rise && state == CAP_IR)
			ir_shift <= STTAP_IR_CAPTURE;
		else if (tck_rise && in_sh_ir)
			ir_shift <= {tdi_s, ir_shift[STTAP_IR_W-1:1]};
	end

	// only non-bypass codes select the data shift register
	assign bypass_active = (active_instr == STTAP_IR_BYPASS);

	// data registers: one-bit bypass or a sample register of the inputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bypass_reg <= STTAP_BYPASS_CAPTURE;
			dr_shift <= '0;
		end
		else if (tck_rise && state == CAP_DR)
		begin
			bypass_reg <= STTAP_BYPASS_CAPTURE;
			dr_shift <= fin_s2;
		end
		else if (tck_rise && in_sh_dr)
		begin
			if (bypass_active)
				bypass_reg <= tdi_s;
			else
				dr_shift <= {tdi_s, dr_shift[DATA_W-1:1]};
		end
	end

	// input pins sampled on rising edge, passed through at falling edge so the
	// latches keep working normally; no test mode drive is implemented
	always_ff @(posedge clk)
	begin
		if (rst)
			func_samp <= '0;
		else if (tck_rise)
			func_samp <= fin_s2;
	end

	wire shift_bit = in_sh_ir ? ir_shift[0] : (bypass_active ? bypass_reg : dr_shift[0]);

	// all outputs except tap_state update on the falling test clock edge; tap_state follows the rising edge
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tdo <= '0;
			func_out <= '0;
			active_instr <= STTAP_IR_RESET;
			data_update <= '0;
		end
		else if (tck_fall)
		begin
			func_out <= func_samp;
			tdo.oe <= in_sh_ir | in_sh_dr;
			if (in_sh_ir | in_sh_dr)
				tdo.data <= shift_bit;
			if (state == UPD_IR)
				active_instr <= ir_shift;
			else if (state == TLR)
				active_instr <= STTAP_IR_RESET;
			if (state == UPD_DR && !bypass_active)
				data_update <= dr_shift;
		end
	end

	chk_exit_hiz: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && (state == EX1_IR || state == EX1_DR)) |=> !tdo.oe)
		else $error("serial output still driven after exit1 fall");

	chk_ir_capture: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && state == CAP_IR) |=> (ir_shift == STTAP_IR_CAPTURE))
		else $error("instruction capture value wrong");

	chk_byp_capture: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && state == CAP_DR) |=> (bypass_reg == 1'b0))
		else $error("bypass did not capture zero");

	chk_tdo_fall_only: assert property (@(posedge clk) disable iff (rst)
		!tck_fall |=> $stable(tdo) && $stable(func_out))
		else $error("output changed away from falling edge");

	chk_state_rise_only: assert property (@(posedge clk) disable iff (rst)
		!tck_rise |=> $stable(state))
		else $error("state moved without rising edge");

	chk_shift_oe: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && (in_sh_ir || in_sh_dr)) |=> tdo.oe)
		else $error("serial output not enabled in shift");

	chk_ir_shift: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && in_sh_ir) |=> (ir_shift[STTAP_IR_W-1] == $past(tdi_s)))
		else $error("instruction shift lost input bit");

	chk_update_ir: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && state == UPD_IR) |=> (active_instr == $past(ir_shift)))
		else $error("active instruction not updated");

	chk_byp_delay: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && in_sh_dr && bypass_active) |=> (bypass_reg == $past(tdi_s)))
		else $error("bypass stage did not take input");

	// scan output must come from the stage selected by the state and the active instruction
	chk_oe_off_idle: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && !(in_sh_ir || in_sh_dr)) |=> !tdo.oe)
		else $error("serial output driven outside shift states");

	chk_tdo_data_hold: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && !(in_sh_ir || in_sh_dr)) |=> $stable(tdo.data))
		else $error("serial output value moved outside shift states");

	chk_tdo_ir_bit: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && in_sh_ir) |=> (tdo.data == $past(ir_shift[0])))
		else $error("instruction bit not presented on serial output");

	chk_tdo_byp_bit: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && in_sh_dr && bypass_active) |=> (tdo.data == $past(bypass_reg)))
		else $error("bypass stage not presented on serial output");

	chk_tdo_dr_bit: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && in_sh_dr && !bypass_active) |=> (tdo.data == $past(dr_shift[0])))
		else $error("sample register bit not presented on serial output");

	chk_update_dr: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && state == UPD_DR && !bypass_active) |=> (data_update == $past(dr_shift)))
		else $error("update stage did not take shifted data");

	chk_update_dr_byp: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && state == UPD_DR && bypass_active) |=> $stable(data_update))
		else $error("update stage changed under bypass");

	chk_dr_hold_byp: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && in_sh_dr && bypass_active) |=> $stable(dr_shift))
		else $error("sample register shifted under bypass");

	chk_func_pass: assert property (@(posedge clk) disable iff (rst)
		tck_fall |=> (func_out == $past(func_samp)))
		else $error("functional output not passed at fall");

	chk_func_sample: assert property (@(posedge clk) disable iff (rst)
		tck_rise |=> (func_samp == $past(fin_s2)))
		else $error("functional input not sampled at rise");

	chk_tlr_bypass: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && state == TLR) |=> (active_instr == STTAP_IR_RESET))
		else $error("reset state did not force bypass");

	// hold checks catch a stray enable that would corrupt a stage between edges
	chk_ir_hold: assert property (@(posedge clk) disable iff (rst)
		!(tck_rise && (in_sh_ir || state == CAP_IR)) |=> $stable(ir_shift))
		else $error("instruction stage moved outside capture or shift");

	chk_instr_hold: assert property (@(posedge clk) disable iff (rst)
		!(tck_fall && (state == UPD_IR || state == TLR)) |=> $stable(active_instr))
		else $error("active instruction moved outside update");

	chk_dr_capture: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && state == CAP_DR) |=> (dr_shift == $past(fin_s2)))
		else $error("sample register did not capture inputs");

	chk_dr_shift_in: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && in_sh_dr && !bypass_active) |=> (dr_shift[DATA_W-1] == $past(tdi_s)))
		else $error("sample register lost input bit");

	chk_ir_to_exit: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && in_sh_ir && tms_s) |=> (state == EX1_IR && ir_shift[STTAP_IR_W-1] == $past(tdi_s)))
		else $error("last instruction bit not shifted on exit");

	chk_cap_to_shift: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && state == CAP_IR && !tms_s) |=> (state == SH_IR && ir_shift == STTAP_IR_CAPTURE))
		else $error("instruction shift not entered with captured word");

	chk_dr_enter_shift: assert property (@(posedge clk) disable iff (rst)
		(tck_rise && state == CAP_DR && !tms_s) |=> (state == SH_DR))
		else $error("data shift not entered from capture");
endmodule

// File: sttap_master_model.sv
`timescale 1ns/1ns
module sttap_master_model
(
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_data,
	input wire logic tdo_oe
);
	// clock stands low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// mode and data set at the fall, rise advances; tdo read just before the rise
	task automatic step(input logic m, input logic d, output logic q, output logic e);
		tms = m;
		tdi = d;
		#62;
		q = tdo_data;
		e = tdo_oe;
		tck = 1'b1;
		#40;
		// hold time over, so the data line stops showing the old bit
		tdi = ~d;
		#23;
		tck = 1'b0;
	endtask
endmodule

// File: sttap_pkg.sv
package sttap_pkg;
	localparam int STTAP_IR_W = 8;
	localparam logic [7:0] STTAP_IR_CAPTURE = 8'h81;
	localparam logic [7:0] STTAP_IR_BYPASS = 8'hff;
	localparam logic [7:0] STTAP_IR_RESET = 8'hff;
	localparam logic STTAP_BYPASS_CAPTURE = 1'b0;

	typedef enum {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} sttap_state_t;

	// serial output pin as output value plus enable
	typedef struct packed {
		logic data;
		logic oe;
	} sttap_tdo_t;
endpackage

// File: tb.sv
`timescale 1ns/1ns
module tb
	import sttap_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tck;
	logic tms;
	logic tdi;
	logic q;
	logic e;
	logic [7:0] func_in = 8'h00;
	logic [7:0] func_out;
	logic [7:0] active_instr;
	logic [7:0] data_update;
	logic bypass_active;
	sttap_tdo_t tdo;
	sttap_state_t tap_state;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	sttap_engine u_sttap_engine (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .func_in(func_in),
		.tdo(tdo), .func_out(func_out), .bypass_active(bypass_active), .active_instr(active_instr),
		.data_update(data_update), .tap_state(tap_state));
	sttap_master_model u_sttap_master_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo_data(tdo.data),
		.tdo_oe(tdo.oe));
	task automatic wrap_up();
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input logic m, input logic d);
		u_sttap_master_model.step(m, d, q, e);
	endtask
	// from idle or an update state to update-ir, checking the captured word on the way out
	task automatic ir_scan(input logic [7:0] val);
		logic [3:0] pat;
		pat = 4'b0011;
		for (int i = 0; i < 4; i++)
			step(pat[i], 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			step(i == 7, val[i]);
			check({6'h00, e, q}, {6'h00, 1'b1, STTAP_IR_CAPTURE[i]});
		end
		step(1'b1, 1'b0);
		check({7'h00, e}, 8'h00);
		#40;
		check(active_instr, val);
		check({7'h00, bypass_active}, {7'h00, val == STTAP_IR_BYPASS});
	endtask
	// bypass data scan of 101, then back to reset
	task automatic dr_bypass();
		logic [2:0] din;
		logic [2:0] dout;
		din = 3'b101;
		dout = 3'b010;
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			step(i == 2, din[i]);
			check({6'h00, e, q}, {6'h00, 1'b1, dout[i]});
		end
		step(1'b1, 1'b0);
		check({7'h00, e}, 8'h00);
		for (int i = 0; i < 3; i++)
			step(1'b1, 1'b0);
		#40;
		check(8'(tap_state), 8'(TLR));
		check(func_out, 8'h5a);
		check(data_update, 8'h3c);
	endtask
	// sample register scan under instruction 00: captured inputs out, new word into the update stage
	task automatic dr_sample(input logic [7:0] val);
		logic [7:0] smp;
		smp = 8'h5a;
		@(posedge clk);
		#1;
		func_in = smp;
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			step(i == 7, val[i]);
			check({6'h00, e, q}, {6'h00, 1'b1, smp[i]});
		end
		step(1'b1, 1'b0);
		check({7'h00, e}, 8'h00);
		#40;
		check(data_update, val);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		func_in = 8'ha5;
		step(1'b0, 1'b0);
		ir_scan(8'h00);
		dr_sample(8'h3c);
		ir_scan(8'hff);
		dr_bypass();
		wrap_up();
	end
endmodule
